/* bench/tdcf_host_model.sv */
// Management bus host issuing single-byte reads and writes.
// Assumes the design answers a read on the same edge that takes it.
`timescale 1ns/1ps
module tdcf_host_model (
   input wire logic clk,
   output tdcf_pkg::tdcf_byte_req_t req,
   input wire tdcf_pkg::tdcf_byte_rsp_t rsp
);
   initial req = '0;
   task xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] din, output tdcf_pkg::tdcf_byte_rsp_t r);
      @(posedge clk);
      // Writes take the unlock command as already sent; this block never sees it
      #1 req = '{wr, !wr, cmd, din};
      @(posedge clk);
      // Idle lines show inverted leftovers so stale data is never mistaken
      #1 req = '{1'b0, 1'b0, ~cmd, ~din};
      r = rsp;
   endtask : xfer
endmodule : tdcf_host_model

/* bench/tdcf_regs_block_props.sv */
// Port checker for the threshold, DAC and cable fault registers.
// Assumes synchronous active high reset on clk; bound to every instance.
`timescale 1ns/1ps
module tdcf_regs_block_props (
   input wire logic clk,
   input wire logic reset,
   input wire tdcf_pkg::tdcf_byte_req_t bus_req,
   input wire logic clear_faults,
   input wire logic unknown_alert_mask,
   input wire tdcf_pkg::tdcf_byte_rsp_t bus_rsp,
   input wire logic [3:0] first_comparator_threshold,
   input wire logic [3:0] second_comparator_threshold,
   input wire logic [5:0] current_dac_pin_code,
   input wire logic current_dac_pin_enable,
   input wire logic [5:0] voltage_dac_pin_code,
   input wire tdcf_pkg::tdcf_fault_t input_cable_fault_flags
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic wr, flt, alrt;
   assign wr = bus_req.write && !bus_req.read;
   assign flt = input_cable_fault_flags.input_cable_fault_bit;
   assign alrt = input_cable_fault_flags.alert;
   rd_answer_a: assert property (bus_req.read && !bus_req.write |=> bus_rsp.valid) else $error("no answer");
   thr_write_a: assert property (wr && bus_req.command == 8'heb |=>
      {second_comparator_threshold, first_comparator_threshold} == $past(bus_req.data)) else $error("thr");
   cdac_write_a: assert property (wr && bus_req.command == 8'hf0 |=>
      current_dac_pin_enable == !$past(bus_req.data[5]) && current_dac_pin_code == $past(bus_req.data[5:0]))
      else $error("cdac");
   vdac_write_a: assert property (wr && bus_req.command == 8'hf1 |=>
      voltage_dac_pin_code == $past(bus_req.data[5:0])) else $error("vdac");
   flag_group_a: assert property (input_cable_fault_flags.status_byte_unknown == flt &&
      input_cable_fault_flags.status_word_unknown == flt) else $error("flags split");
   fault_hold_a: assert property (flt && !clear_faults |=> flt) else $error("fault lost");
   alert_mask_a: assert property ($rose(flt) && $past(unknown_alert_mask) |-> !alrt) else $error("mask");
   alert_cause_a: assert property (alrt |-> flt) else $error("alert alone");
   clear_cause_a: assert property ($fell(flt) |-> $past(clear_faults)) else $error("clear");
endmodule : tdcf_regs_block_props
bind tdcf_regs_block tdcf_regs_block_props u_props (.*);

/* bench/tdcf_regs_block_tb_top.sv */
// Self-checking bench for the threshold, DAC and cable fault registers.
// Assumes the host model serialises bus requests.
`timescale 1ns/1ps
module tdcf_regs_block_tb_top;
   logic clk = 0, reset = 1, mask = 0, clr = 0, f_exp = 0, a_exp = 0;
   logic [9:0] rdg = 10'h3ff;
   int error_cnt = 0, n_compared = 0, seed = 63887;
   logic [7:0] cmds [5] = '{8'heb, 8'hec, 8'hed, 8'hf0, 8'hf1};
   logic [7:0] rsts [5] = '{8'hff, 8'h9d, 8'hff, 8'h00, 8'h00};
   logic [7:0] d;
   tdcf_pkg::tdcf_byte_req_t req;
   tdcf_pkg::tdcf_byte_rsp_t rsp, r;
   tdcf_pkg::tdcf_fault_t flt;
   logic [3:0] th1, th2;
   logic en;
   always #5 clk = ~clk;
   tdcf_host_model u_host (.clk(clk), .req(req), .rsp(rsp));
   tdcf_regs_block u_dut (.clk(clk), .reset(reset), .bus_req(req), .input_voltage_reading(rdg),
      .unknown_alert_mask(mask), .clear_faults(clr), .bus_rsp(rsp), .first_comparator_threshold(th1),
      .second_comparator_threshold(th2), .current_dac_pin_code(), .current_dac_pin_enable(en),
      .voltage_dac_pin_code(), .input_cable_fault_flags(flt));
   function automatic logic over(logic [9:0] v, logic [7:0] s, logic [7:0] dr);
      return $signed({1'b0, v[9:8], s}) - $signed({1'b0, v}) > $signed({3'b0, dr});
   endfunction : over
   task chk(logic [7:0] got, logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task rd(logic [7:0] c, logic h, logic [7:0] e);
      u_host.xfer(1'b0, c, 8'h00, r);
      chk({6'h0, r.valid, r.hit}, {7'h1, h});
      chk(r.data, e);
   endtask : rd
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   initial begin
      #100000 error_cnt++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clk);
      #1 reset = 0;
      foreach (cmds[i]) rd(cmds[i], 1'b1, rsts[i]);
      chk({4'h0, th1}, 8'h0f);
      chk({4'h0, th2}, 8'h0f);
      rd(8'hee, 1'b0, 8'h00);
      u_host.xfer(1'b1, 8'hf0, 8'h20, r);
      chk({7'h0, en}, 8'h00);
      foreach (cmds[i]) begin
         d = 8'($random(seed));
         u_host.xfer(1'b1, cmds[i], d, r);
         rd(cmds[i], 1'b1, d & ((i > 2) ? 8'h3f : 8'hff));
      end
      u_host.xfer(1'b1, 8'hec, 8'h80, r);
      u_host.xfer(1'b1, 8'hed, 8'h10, r);
      repeat (400) begin
         @(posedge clk);
         #1 chk({4'h0, flt}, {4'h0, f_exp, f_exp, f_exp, a_exp});
         rdg = 10'($random(seed));
         mask = 1'($random(seed));
         clr = ($random(seed) & 3) == 0;
         if (over(rdg, 8'h80, 8'h10)) begin
            f_exp = 1'b1;
            a_exp = a_exp | !mask;
         end else if (clr) begin
            f_exp = 1'b0;
            a_exp = 1'b0;
         end
      end
      end_sim();
   end
endmodule : tdcf_regs_block_tb_top

/* pkg/tdcf_pkg.sv */
// Types shared by the threshold, DAC and cable fault register block.
// Assumes the command byte and data byte arrive together from the management bus engine.
package tdcf_pkg;
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] command;
      logic [7:0] data;
   } tdcf_byte_req_t;

   typedef struct packed {
      logic valid;
      logic hit;
      logic [7:0] data;
   } tdcf_byte_rsp_t;

   typedef struct packed {
      logic status_byte_unknown;
      logic status_word_unknown;
      logic input_cable_fault_bit;
      logic alert;
   } tdcf_fault_t;
endpackage : tdcf_pkg

/* pkg/tdcf_regs.svh */
// Offsets, reset values and field positions of the threshold, DAC and cable fault registers.
// Assumes the command byte of a single-byte read or write selects one register.
`ifndef TDCF_REGS_SVH
`define TDCF_REGS_SVH
`define TDCF_CMD_COMPARATOR_THRESHOLDS 8'heb
`define TDCF_CMD_SUPPLY_VOLTAGE_NOMINAL 8'hec
`define TDCF_CMD_CABLE_DROP_LIMIT 8'hed
`define TDCF_CMD_CURRENT_DAC_CODE 8'hf0
`define TDCF_CMD_VOLTAGE_DAC_CODE 8'hf1
`define TDCF_RST_COMPARATOR_THRESHOLDS 8'hff
`define TDCF_RST_SUPPLY_VOLTAGE_NOMINAL 8'h9d
`define TDCF_RST_CABLE_DROP_LIMIT 8'hff
`define TDCF_RST_CURRENT_DAC_CODE 8'h00
`define TDCF_RST_VOLTAGE_DAC_CODE 8'h00
`define TDCF_DAC_CODE_MSB 5
`define TDCF_DAC_DISCONNECT_BIT 5
`endif

/* rtl/tdcf_regs_block.sv */
// Five byte-wide configuration registers plus input cable fault detection.
// Assumes a management bus engine delivers decoded single-byte reads and writes,
// the ADC supplies a 10-bit input voltage reading on this clock, and the status
// block supplies the alert mask bit and a one-cycle clear-faults strobe.
`timescale 1ns/1ps
`include "tdcf_regs.svh"

// Contract
// - Threshold register holds two 4-bit codes, bits 3:0 and 7:4.
// - Threshold nibbles drive the DACs continuously and reset to all ones.
// - Supply register holds low eight bits of 10-bit voltage, reset 0x9d.
// - Cable drop register holds 8-bit limit, reset 0xff.
// - Continuously compare supply minus measured input against cable drop limit.
// - Difference above limit sets cable fault flags and alert.
// - Fault sets unknown bits of status byte, status word, and vendor status.
// - Alert suppressed while the unknown-fault mask bit is set.
// - Fault and alert clear only after drop falls and clear-faults follows.
// - Current DAC register holds 6-bit sink code, reset 0x00.
// - Current DAC code top bit set disconnects the pin.
// - Voltage DAC register holds 6-bit code up to 0x3f, reset 0x00.
// - Registers reached only by single-byte reads and writes.
module tdcf_regs_block (
   input wire logic clk,
   input wire logic reset,
   input wire tdcf_pkg::tdcf_byte_req_t bus_req,
   input wire logic [9:0] input_voltage_reading,
   input wire logic unknown_alert_mask,
   input wire logic clear_faults,
   output tdcf_pkg::tdcf_byte_rsp_t bus_rsp,
   output logic [3:0] first_comparator_threshold,
   output logic [3:0] second_comparator_threshold,
   output logic [5:0] current_dac_pin_code,
   output logic current_dac_pin_enable,
   output logic [5:0] voltage_dac_pin_code,
   output tdcf_pkg::tdcf_fault_t input_cable_fault_flags
);

   function automatic logic [7:0] lookup(
      input logic [7:0] cmd,
      input logic [7:0] thr,
      input logic [7:0] sup,
      input logic [7:0] drp,
      input logic [7:0] cur,
      input logic [7:0] vol
   );
      logic [7:0] v;
      v = 8'h00;
      unique case (cmd)
         `TDCF_CMD_COMPARATOR_THRESHOLDS: begin
            v = thr;
         end
         `TDCF_CMD_SUPPLY_VOLTAGE_NOMINAL: begin
            v = sup;
         end
         `TDCF_CMD_CABLE_DROP_LIMIT: begin
            v = drp;
         end
         `TDCF_CMD_CURRENT_DAC_CODE: begin
            v = cur;
         end
         `TDCF_CMD_VOLTAGE_DAC_CODE: begin
            v = vol;
         end
         // Unmapped commands read as zero rather than aliasing onto a real register
         default: begin
            v = 8'h00;
         end
      endcase
      return v;
   endfunction : lookup

   function automatic logic is_mapped(
      input logic [7:0] cmd
   );
      logic hit;
      hit = 1'b0;
      unique case (cmd)
         `TDCF_CMD_COMPARATOR_THRESHOLDS,
         `TDCF_CMD_SUPPLY_VOLTAGE_NOMINAL,
         `TDCF_CMD_CABLE_DROP_LIMIT,
         `TDCF_CMD_CURRENT_DAC_CODE,
         `TDCF_CMD_VOLTAGE_DAC_CODE: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction : is_mapped

   // Both strobes high is no legal single-byte transfer, so such a request is dropped
   function automatic logic is_write(
      input tdcf_pkg::tdcf_byte_req_t req
   );
      return req.write && !req.read;
   endfunction : is_write

   function automatic logic is_read(
      input tdcf_pkg::tdcf_byte_req_t req
   );
      return req.read && !req.write;
   endfunction : is_read

   function automatic logic write_hits(
      input tdcf_pkg::tdcf_byte_req_t req,
      input logic [7:0] cmd
   );
      return is_write(req) && (req.command == cmd);
   endfunction : write_hits

   // Only six code bits exist; bits 7:6 always read back as zero
   function automatic logic [7:0] dac_field(
      input logic [7:0] data
   );
      return {2'h0, data[`TDCF_DAC_CODE_MSB:0]};
   endfunction : dac_field

   // Negative when the input sits above the programmed supply, so that case never faults
   function automatic logic signed [11:0] cable_drop(
      input logic [9:0] reading,
      input logic [7:0] supply
   );
      return $signed({2'b00, reading[9:8], supply}) - $signed({2'b00, reading});
   endfunction : cable_drop

   logic [7:0] thresholds_q, thresholds_d;
   logic [7:0] supply_q, supply_d;
   logic [7:0] drop_q, drop_d;
   logic [7:0] cur_dac_q, cur_dac_d;
   logic [7:0] vol_dac_q, vol_dac_d;
   tdcf_pkg::tdcf_byte_rsp_t rsp_q, rsp_d;

   // Cable fault state
   logic fault_q, fault_d;
   logic alert_q, alert_d;
   logic over_limit;
   logic signed [11:0] drop_now;

   // Comparator thresholds
   always_comb begin
      thresholds_d = thresholds_q;
      if (write_hits(bus_req, `TDCF_CMD_COMPARATOR_THRESHOLDS)) begin
         thresholds_d = bus_req.data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         thresholds_q <= `TDCF_RST_COMPARATOR_THRESHOLDS;
      end else begin
         thresholds_q <= thresholds_d;
      end
   end

   // Supply voltage low byte
   always_comb begin
      supply_d = supply_q;
      if (write_hits(bus_req, `TDCF_CMD_SUPPLY_VOLTAGE_NOMINAL)) begin
         supply_d = bus_req.data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         supply_q <= `TDCF_RST_SUPPLY_VOLTAGE_NOMINAL;
      end else begin
         supply_q <= supply_d;
      end
   end

   // Cable drop limit
   always_comb begin
      drop_d = drop_q;
      if (write_hits(bus_req, `TDCF_CMD_CABLE_DROP_LIMIT)) begin
         drop_d = bus_req.data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         drop_q <= `TDCF_RST_CABLE_DROP_LIMIT;
      end else begin
         drop_q <= drop_d;
      end
   end

   // Current DAC code; bit 5 set parks the DAC off its pin but the code is kept
   always_comb begin
      cur_dac_d = cur_dac_q;
      if (write_hits(bus_req, `TDCF_CMD_CURRENT_DAC_CODE)) begin
         cur_dac_d = dac_field(bus_req.data);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cur_dac_q <= `TDCF_RST_CURRENT_DAC_CODE;
      end else begin
         cur_dac_q <= cur_dac_d;
      end
   end

   // Voltage DAC code
   always_comb begin
      vol_dac_d = vol_dac_q;
      if (write_hits(bus_req, `TDCF_CMD_VOLTAGE_DAC_CODE)) begin
         vol_dac_d = dac_field(bus_req.data);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         vol_dac_q <= `TDCF_RST_VOLTAGE_DAC_CODE;
      end else begin
         vol_dac_q <= vol_dac_d;
      end
   end

   // Read answer stands for exactly one cycle after the read is taken
   always_comb begin
      rsp_d = '0;
      if (is_read(bus_req)) begin
         rsp_d.valid = 1'b1;
         rsp_d.hit = is_mapped(bus_req.command);
         rsp_d.data = lookup(bus_req.command, thresholds_q, supply_q, drop_q, cur_dac_q, vol_dac_q);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   // Supply high bits follow the live reading, as the host does when it rebuilds the code
   always_comb begin
      drop_now = cable_drop(input_voltage_reading, supply_q);
      over_limit = drop_now > $signed({4'h0, drop_q});
   end

   // Fault flag: a new over-limit condition beats a clear in the same cycle
   always_comb begin
      fault_d = fault_q;
      if (clear_faults && !over_limit) begin
         fault_d = 1'b0;
      end
      if (over_limit) begin
         fault_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= fault_d;
      end
   end

   // Mask is looked at every cycle the drop is over limit; a masked fault raises the alert if the mask drops while still over
   always_comb begin
      alert_d = alert_q;
      if (clear_faults && !over_limit) begin
         alert_d = 1'b0;
      end
      if (over_limit && !unknown_alert_mask) begin
         alert_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         alert_q <= 1'b0;
      end else begin
         alert_q <= alert_d;
      end
   end

   // Register and pin outputs are wired from the flops above; only the current DAC pin enable is inverted
   always_comb begin
      bus_rsp = rsp_q;
      first_comparator_threshold = thresholds_q[3:0];
      second_comparator_threshold = thresholds_q[7:4];
      current_dac_pin_code = cur_dac_q[5:0];
      current_dac_pin_enable = !cur_dac_q[`TDCF_DAC_DISCONNECT_BIT];
      voltage_dac_pin_code = vol_dac_q[5:0];
   end

   // All three status bits mirror one flag; they differ only in which status register shows them
   always_comb begin
      input_cable_fault_flags.status_byte_unknown = fault_q;
      input_cable_fault_flags.status_word_unknown = fault_q;
      input_cable_fault_flags.input_cable_fault_bit = fault_q;
      input_cable_fault_flags.alert = alert_q;
   end

endmodule : tdcf_regs_block
